// ### ecd_pkg.sv
// package: constants for the command register schedule and doorbell logic
`default_nettype none
package ecd_pkg;
  // ************************************************
  // register layout
  // ************************************************
  localparam int CMD_WIDTH = 32;
  localparam int DOORBELL_BIT = 6;
  localparam int ASYNC_EN_BIT = 5;
  localparam int PERIODIC_EN_BIT = 4;
  localparam int THRESH_LSB = 16;
  localparam int THRESH_WIDTH = 8;
  localparam logic [7:0] THRESH_RESET = 8'h08;
  localparam logic ENABLE_RESET = 1'b0;
  // ************************************************
  // timing: one micro-frame is 125 us
  // ************************************************
  localparam int CLK_MHZ = 100;
  localparam int UFRAME_US = 125;
  localparam int UFRAME_CYCLES = UFRAME_US * CLK_MHZ;
  // doorbell handshake states
  typedef enum logic [1:0] {
    ECD_IDLE = 2'b00,
    ECD_WAIT_ADV = 2'b01,
    ECD_FLAG_SET = 2'b10
  } ecd_state_t;
endpackage : ecd_pkg
`default_nettype wire

// ### ecd_if.sv
// interface: micro-frame enable between the tick divider and the register logic
`default_nettype none
interface ecd_tick_if;
  logic uframe_tick;
  modport source (output uframe_tick);
  modport sink (input uframe_tick);
endinterface : ecd_tick_if
`default_nettype wire

// ### ecd_uframe_div.sv
// file: micro-frame enable pulse divider
`default_nettype none
module ecd_uframe_div
  import ecd_pkg::*;
#(
  parameter int CYCLES = UFRAME_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pulse out
  ecd_tick_if.source tick
);
  logic [15:0] count_reg;
  // free-running count, one pulse per micro-frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= 16'h0000;
    end else if (count_reg == 16'(CYCLES - 1)) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end
  assign tick.uframe_tick = (count_reg == 16'(CYCLES - 1));
endmodule : ecd_uframe_div
`default_nettype wire

// ### ecd_cmd_sched.sv
// file: command register schedule enables, doorbell, threshold-paced interrupt
`default_nettype none
// ************************************************
// command register logic
// ************************************************
module ecd_cmd_sched
  import ecd_pkg::*;
#(
  parameter int UFRAME_CYC = UFRAME_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic cmd_write,
  input wire logic [CMD_WIDTH-1:0] cmd_wdata,
  output logic [CMD_WIDTH-1:0] host_command_reg,
  // status and interrupt enable
  input wire logic async_advance_irq_enable,
  input wire logic async_advance_flag_clear,
  output logic async_advance_flag,
  output logic irq,
  // schedule engine
  input wire logic async_advanced,
  input wire logic cache_evicted,
  output logic async_fetch_enable,
  output logic periodic_fetch_enable,
  input wire logic [31:0] async_list_pointer,
  input wire logic [31:0] periodic_frame_list_pointer,
  output logic [31:0] async_fetch_addr,
  output logic [31:0] periodic_fetch_addr
);
  ecd_tick_if tick_bus ();

  // stored fields and internal state
  logic async_sched_enable_reg;
  logic periodic_sched_enable_reg;
  logic async_advance_doorbell_reg;
  logic [THRESH_WIDTH-1:0] irq_threshold_ctrl_reg;
  logic [THRESH_WIDTH-1:0] thresh_count_reg;
  logic flag_reg;
  logic irq_reg;
  logic boundary;
  logic ring_req;
  logic advance_hit;
  ecd_state_t state_reg;

  ecd_uframe_div #(.CYCLES(UFRAME_CYC)) u_div (
    .clk(clk),
    .reset(reset),
    .tick(tick_bus.source)
  );

  // ************************************************
  // decoding helpers
  // ************************************************
  // a write rings only when it carries a one in the doorbell position
  function automatic logic rings_doorbell(
    input logic write,
    input logic [CMD_WIDTH-1:0] data
  );
    return write && data[DOORBELL_BIT];
  endfunction : rings_doorbell

  // an advance counts only once the engine reports its caches flushed
  function automatic logic advance_complete(
    input logic advanced,
    input logic evicted
  );
    return advanced && evicted;
  endfunction : advance_complete

  // both decodes are named once so every process sees the same condition
  assign ring_req = rings_doorbell(cmd_write, cmd_wdata);
  assign advance_hit = advance_complete(async_advanced, cache_evicted);

  // ************************************************
  // software controls
  // ************************************************
  // async schedule enable, plain read/write; off after reset so nothing is fetched early
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      async_sched_enable_reg <= ENABLE_RESET;
    end else if (cmd_write) begin
      async_sched_enable_reg <= cmd_wdata[ASYNC_EN_BIT];
    end
  end

  // periodic schedule enable, plain read/write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periodic_sched_enable_reg <= ENABLE_RESET;
    end else if (cmd_write) begin
      periodic_sched_enable_reg <= cmd_wdata[PERIODIC_EN_BIT];
    end
  end

  // threshold field; a written zero is kept and later paced as one micro-frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_threshold_ctrl_reg <= THRESH_RESET;
    end else if (cmd_write) begin
      irq_threshold_ctrl_reg <= cmd_wdata[THRESH_LSB +: THRESH_WIDTH];
    end
  end

  // doorbell: set by a written one, cleared only by the controller
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      async_advance_doorbell_reg <= 1'b0;
    end else if (ring_req) begin
      async_advance_doorbell_reg <= 1'b1;
    end else if (state_reg == ECD_FLAG_SET) begin
      async_advance_doorbell_reg <= 1'b0;
    end
  end

  // ************************************************
  // doorbell handshake
  // ************************************************
  // wait for an advance with caches evicted, then flag, then drop the bell
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ECD_IDLE;
    end else begin
      case (state_reg)
        ECD_IDLE: begin
          if (async_advance_doorbell_reg) begin
            state_reg <= ECD_WAIT_ADV;
          end
        end
        ECD_WAIT_ADV: begin
          // an inactive schedule never advances; software must avoid this
          if (advance_hit) begin
            state_reg <= ECD_FLAG_SET;
          end
        end
        ECD_FLAG_SET: begin
          // one cycle here lets the bell drop only after the flag is visible
          state_reg <= ECD_IDLE;
        end
        default: begin
          state_reg <= ECD_IDLE;
        end
      endcase
    end
  end

  // sticky status flag; a set beats a same-cycle clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (state_reg == ECD_WAIT_ADV && advance_hit) begin
      flag_reg <= 1'b1;
    end else if (async_advance_flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // ************************************************
  // interrupt pacing
  // ************************************************
  // counts micro-frames; threshold zero treated as one to avoid stalling
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thresh_count_reg <= '0;
    end else if (tick_bus.uframe_tick) begin
      if (boundary) begin
        thresh_count_reg <= '0;
      end else begin
        thresh_count_reg <= thresh_count_reg + 8'h01;
      end
    end
  end
  // combinational so the interrupt flop samples it on the tick edge itself
  assign boundary = tick_bus.uframe_tick &&
    (thresh_count_reg + 8'h01 >= irq_threshold_ctrl_reg);

  // interrupt follows the flag; it rises only at a boundary but drops as soon as flag or enable is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else if (!(flag_reg && async_advance_irq_enable)) begin
      irq_reg <= 1'b0;
    end else if (boundary) begin
      irq_reg <= 1'b1;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // readback: reserved bits and fields kept elsewhere read as zero
  always_comb begin
    host_command_reg = '0;
    host_command_reg[DOORBELL_BIT] = async_advance_doorbell_reg;
    host_command_reg[ASYNC_EN_BIT] = async_sched_enable_reg;
    host_command_reg[PERIODIC_EN_BIT] = periodic_sched_enable_reg;
    host_command_reg[THRESH_LSB +: THRESH_WIDTH] = irq_threshold_ctrl_reg;
  end

  // status and interrupt straight from their flip-flops
  assign async_advance_flag = flag_reg;
  assign irq = irq_reg;

  // fetch gating; a disabled list presents address zero, never a stale pointer
  assign async_fetch_enable = async_sched_enable_reg;
  assign periodic_fetch_enable = periodic_sched_enable_reg;
  assign async_fetch_addr = async_sched_enable_reg ? async_list_pointer : 32'h0000_0000;
  assign periodic_fetch_addr =
    periodic_sched_enable_reg ? periodic_frame_list_pointer : 32'h0000_0000;
endmodule : ecd_cmd_sched
`default_nettype wire

// ### ecd_host_model.sv
// partner model: host driver software writing the command register
`default_nettype none
module ecd_host_model
  import ecd_pkg::*;
(
  // register port
  input wire logic clk,
  output logic cmd_write,
  output logic [CMD_WIDTH-1:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_write = 1'b0;
    cmd_wdata = 32'h0;
  end
  // one write held across one edge; a ring is dropped unless the word enables async
  task automatic wr(input logic [CMD_WIDTH-1:0] d);
    @(posedge clk);
    #1;
    cmd_write = 1'b1;
    cmd_wdata = d[ASYNC_EN_BIT] ? d : d & ~(32'h1 << DOORBELL_BIT);
    @(posedge clk);
    #1;
    cmd_write = 1'b0;
    cmd_wdata = ~cmd_wdata; // released data must not look valid
  endtask : wr
endmodule : ecd_host_model
`default_nettype wire

// ### ecd_cmd_sched_chk.sv
// checker: port assertions for the command register logic
`default_nettype none
module ecd_cmd_sched_chk
  import ecd_pkg::*;
#(parameter int UFRAME_CYC = UFRAME_CYCLES) (
  // ports watched
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_write,
  input wire logic [CMD_WIDTH-1:0] cmd_wdata,
  input wire logic [CMD_WIDTH-1:0] host_command_reg,
  input wire logic async_advance_irq_enable,
  input wire logic async_advance_flag,
  input wire logic irq,
  input wire logic async_advanced,
  input wire logic cache_evicted,
  input wire logic async_fetch_enable,
  input wire logic [31:0] async_list_pointer,
  input wire logic [31:0] async_fetch_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ring, then an advance seen while already waiting
  sequence s_ring;
    cmd_write && cmd_wdata[6];
  endsequence
  sequence s_adv;
    async_advanced && cache_evicted && host_command_reg[6] && $past(host_command_reg[6]);
  endsequence
  a_ring_sets: assert property (s_ring |=> host_command_reg[6])
    else $error("doorbell not set");
  a_zero_noop: assert property (host_command_reg[6] && !async_advance_flag
    && !(async_advanced && cache_evicted) |=> host_command_reg[6]) else $error("doorbell lost");
  a_flag_set: assert property (s_adv ##0 !async_advance_flag |=> async_advance_flag)
    else $error("flag not set");
  a_db_clear: assert property ($rose(async_advance_flag) && !(cmd_write && cmd_wdata[6])
    |=> !host_command_reg[6]) else $error("doorbell not cleared");
  a_irq_needs: assert property (!async_advance_flag || !async_advance_irq_enable
    |=> !irq) else $error("irq without cause");
  a_irq_cause: assert property ($rose(irq) |-> $past(async_advance_flag)
    && $past(async_advance_irq_enable)) else $error("irq rose wrongly");
  a_write_fields: assert property (cmd_write |=>
    host_command_reg[5:4] == $past(cmd_wdata[5:4])
    && host_command_reg[23:16] == $past(cmd_wdata[23:16])) else $error("fields not written");
  a_async_mux: assert property (async_fetch_enable == host_command_reg[5]
    && async_fetch_addr == (host_command_reg[5] ? async_list_pointer : 32'h0)) else $error("mux");
endmodule : ecd_cmd_sched_chk
bind ecd_cmd_sched ecd_cmd_sched_chk #(.UFRAME_CYC(UFRAME_CYC)) u_ecd_cmd_sched_chk (
  .clk(clk), .reset(reset), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
  .host_command_reg(host_command_reg), .async_advance_irq_enable(async_advance_irq_enable),
  .async_advance_flag(async_advance_flag), .irq(irq), .async_advanced(async_advanced),
  .cache_evicted(cache_evicted), .async_fetch_enable(async_fetch_enable),
  .async_list_pointer(async_list_pointer), .async_fetch_addr(async_fetch_addr));
`default_nettype wire

// ### test_ehci_cmd_schedule_doorbell.sv
// testbench: schedule enables and doorbell handshake
`default_nettype none
module test_ehci_cmd_schedule_doorbell
  import ecd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset = 1'b1, we, ie = 1'b0, clr = 1'b0, adv = 1'b0, ev = 1'b0;
  logic fl, irq, ae, pe;
  logic [31:0] wd, rd, aa, pa, ap = 32'h0000_1000, pp = 32'h0000_2000;
  int mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  ecd_host_model u_ecd_host_model (.clk(clk), .cmd_write(we), .cmd_wdata(wd));
  // short micro-frame keeps threshold waits to tens of cycles
  ecd_cmd_sched #(.UFRAME_CYC(10)) u_ecd_cmd_sched (.clk(clk), .reset(reset), .cmd_write(we),
    .cmd_wdata(wd), .host_command_reg(rd), .async_advance_irq_enable(ie),
    .async_advance_flag_clear(clr), .async_advance_flag(fl), .irq(irq), .async_advanced(adv),
    .cache_evicted(ev), .async_fetch_enable(ae), .periodic_fetch_enable(pe),
    .async_list_pointer(ap), .periodic_frame_list_pointer(pp), .async_fetch_addr(aa),
    .periodic_fetch_addr(pa));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // reset values, both enables, reserved bits dropped
  task automatic t_enables();
    chk("reset readback", 32'h0008_0000, rd);
    u_ecd_host_model.wr(32'h0008_0030);
    chk("fetch enables", 32'h3, {ae, pe});
    chk("async addr", ap, aa);
    chk("periodic addr", pp, pa);
    u_ecd_host_model.wr(32'hff02_ff10);
    chk("readback", 32'h0002_0010, rd);
    chk("async addr off", 32'h0, aa);
  endtask : t_enables
  // ring, hold against a zero write, advance, then threshold-paced irq
  task automatic t_ring(input logic en);
    ie = en;
    u_ecd_host_model.wr(32'h0002_0060);
    u_ecd_host_model.wr(32'h0002_0020);
    chk("doorbell held", 32'h1, rd[6]);
    chk("periodic addr off", 32'h0, pa);
    @(posedge clk);
    #1 adv = 1'b1;
    @(posedge clk);
    #1 chk("flag before evict", 32'h0, fl);
    ev = 1'b1;
    @(posedge clk);
    #1 adv = 1'b0;
    ev = 1'b0;
    chk("flag", 32'h1, fl);
    @(posedge clk);
    #1 chk("doorbell cleared", 32'h0, rd[6]);
    for (int k = 0; k < 30 && irq !== 1'b1; k++) @(posedge clk);
    #1 chk("irq", {31'h0, en}, irq);
    if (en && irq !== 1'b1) results();
    clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    @(posedge clk);
    #1 chk("flag and irq", 32'h0, {fl, irq});
  endtask : t_ring
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    t_enables();
    t_ring(1'b1);
    t_ring(1'b0);
    results();
  end
endmodule : test_ehci_cmd_schedule_doorbell
`default_nettype wire
